// file: design/ipt_unit.sv
// interrupt acceptance, ranking and abort control facing the sequencer
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module ipt_unit #(
	parameter int SYNC_N = 2
) (
	input wire logic REF_CLK_I, // 50 MHz clock
	input wire logic RST_I, // synchronous reset, active high
	// avalon-mm slave
	input wire logic [ipt_pkg::ADDR_W-1:0] AVS_ADDRESS_I, // byte address
	input wire logic AVS_READ_I, // read strobe
	input wire logic AVS_WRITE_I, // write strobe
	input wire logic [3:0] AVS_BYTEENABLE_I, // byte lanes
	input wire logic [31:0] AVS_WRITEDATA_I, // write data
	output logic [31:0] AVS_READDATA_O, // read data
	output logic AVS_WAITREQUEST_O, // stall
	// asynchronous request pins
	input wire logic [ipt_pkg::AS_N-1:0] ASYNC_REQ_I, // power, console, malf, io levels
	output logic [ipt_pkg::AS_N-1:0] ASYNC_ACK_O, // one-cycle acknowledge
	// sequencer side
	input wire logic FAULT_I, // fault detected pulse
	input wire logic [ipt_pkg::FLT_N-1:0] FAULT_CAUSE_I, // cause vector
	input wire logic SVC_I, // supervisor call pulse
	input wire logic SIM_I, // simulated interrupt pulse
	input wire logic BOUNDARY_I, // instruction completed pulse
	input wire logic ITER_END_I, // iteration completed pulse
	input wire logic ITER_INSTR_I, // interruptible instruction active
	input wire logic CTRL_STORE_OP_I, // control-store read/write active
	input wire logic MULTI_OP_I, // load/store multiple or store double
	input wire logic [ipt_pkg::LOC_W-1:0] CUR_LOC_I, // current instruction address
	input wire logic [ipt_pkg::LOC_W-1:0] NEXT_LOC_I, // following instruction address
	input wire logic SW_LOAD_I, // new status word load pulse
	input wire logic SW_LOAD_TEST_I, // load came from status-loading instruction
	input wire logic [ipt_pkg::SW_W-1:0] SW_NEW_I, // new status word
	input wire logic QUEUE_NONEMPTY_I, // system queue not empty
	input wire logic HALT_I, // enter console mode pulse
	input wire logic LIST_OP_I, // list add/remove active
	input wire logic LIST_REMOVE_I, // list remove active
	input wire logic LIST_BODY_OK_I, // body access succeeded pulse
	input wire logic LIST_HDR_OK_I, // header update succeeded pulse
	output ipt_pkg::ipt_take_s TAKE_INFO_O, // acceptance record
	output logic TAKE_O, // acceptance pulse
	output logic WRITE_INHIBIT_O, // suppress instruction writes
	output logic SCRATCH_RESUME_O, // start iteration from scratchpad
	output logic HDR_WR_OK_O, // list header may be written
	output logic LIST_REG_WR_OK_O, // list remove may write registers
	output logic [ipt_pkg::SW_W-1:0] STATUS_WORD_O, // current status word
	output logic RUN_MODE_O, // high in run mode
	output logic WAIT_STATE_O // run mode and waiting
);
	// synchroniser for pin requests
	logic [ipt_pkg::AS_N-1:0] sync_r [SYNC_N];
	logic [ipt_pkg::AS_N-1:0] async_lvl;
	// pins acknowledged but not yet seen low through the synchroniser
	logic [ipt_pkg::AS_N-1:0] held_r, held_nxt;
	logic [ipt_pkg::AS_N-1:0] async_live;
	// state
	logic [ipt_pkg::SW_W-1:0] sw_r, sw_nxt;
	ipt_pkg::ipt_mode_e mode_r, mode_nxt;
	logic queue_r, queue_nxt;
	logic svc_r, svc_nxt;
	logic sim_r, sim_nxt;
	ipt_pkg::ipt_take_s take_r, take_nxt;
	logic take_pulse_r, take_pulse_nxt;
	logic [ipt_pkg::AS_N-1:0] ack_r, ack_nxt;
	logic inhibit_r, inhibit_nxt;
	logic body_ok_r, body_ok_nxt;
	logic hdr_ok_r, hdr_ok_nxt;
	logic resume_r, resume_nxt;
	logic bus_ack_r, bus_ack_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	// combinational helpers
	logic [3:0] cause;
	logic fault_en;
	logic run;
	logic point;
	logic mid_iter;
	logic [ipt_pkg::AS_N-1:0] async_en;
	logic bus_req;
	logic [31:0] wmask;
	logic [31:0] pend_view;
	logic queue_set;
	logic re_exec;

	always_ff @(posedge REF_CLK_I)
	begin
		if (RST_I)
		begin
			for (int i = 0; i < SYNC_N; i++)
			begin
				sync_r[i] <= '0;
			end
		end
		else
		begin
			sync_r[0] <= ASYNC_REQ_I;
			for (int i = 1; i < SYNC_N; i++)
			begin
				sync_r[i] <= sync_r[i-1];
			end
		end
	end
	assign async_lvl = sync_r[SYNC_N-1];
	// an acked level lingers in the synchroniser; never take it twice
	assign async_live = async_lvl & ~held_r;

	// [RQ13] fault cause ranking
	always_comb
	begin
		cause = ipt_pkg::CAUSE_NONE;
		for (int i = ipt_pkg::FLT_N - 1; i >= 0; i--)
		begin
			if (FAULT_CAUSE_I[i])
			begin
				cause = 4'(i);
			end
		end
	end

	// [RQ1] maskable faults and pin requests gated by status word
	always_comb
	begin
		fault_en = FAULT_I && (cause != ipt_pkg::CAUSE_NONE);
		if ((cause == 4'(ipt_pkg::FLT_ACC_FETCH) || cause == 4'(ipt_pkg::FLT_ACC_DATA))
			&& !sw_r[ipt_pkg::SW_ACC_EN_POS])
		begin
			fault_en = 1'b0;
		end
		if (cause == 4'(ipt_pkg::FLT_ARITH) && !sw_r[ipt_pkg::SW_ARITH_EN_POS])
		begin
			fault_en = 1'b0;
		end
		async_en = async_live;
		async_en[ipt_pkg::AS_POWER] = async_live[ipt_pkg::AS_POWER]
			&& sw_r[ipt_pkg::SW_MALF_EN_POS];
		async_en[ipt_pkg::AS_MALF] = async_live[ipt_pkg::AS_MALF]
			&& sw_r[ipt_pkg::SW_MALF_EN_POS];
		async_en[ipt_pkg::AS_IO] = async_live[ipt_pkg::AS_IO]
			&& sw_r[ipt_pkg::SW_IO_EN_POS];
		// [RQ2] console attention has no enable
		async_en[ipt_pkg::AS_CONSOLE] = async_live[ipt_pkg::AS_CONSOLE];
	end

	// [RQ20] acceptance only in run mode; waiting accepts any cycle
	assign run = (mode_r == ipt_pkg::MODE_RUN);
	// [RQ3] boundary point, [RQ4] iteration end point
	assign point = run && (BOUNDARY_I || (ITER_END_I && ITER_INSTR_I)
		|| sw_r[ipt_pkg::SW_WAIT_POS]);
	assign mid_iter = ITER_INSTR_I && !BOUNDARY_I && !CTRL_STORE_OP_I;
	// an unfinished instruction re-executes, control-store ops included
	assign re_exec = ITER_INSTR_I && !BOUNDARY_I;
	// [RQ21] status-loading instruction finds the queue non-empty
	assign queue_set = SW_LOAD_I && SW_LOAD_TEST_I && SW_NEW_I[ipt_pkg::SW_QUEUE_EN_POS]
		&& QUEUE_NONEMPTY_I;

	assign bus_req = (AVS_READ_I || AVS_WRITE_I) && !bus_ack_r;
	assign wmask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
		{8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
	assign pend_view = {20'h0_0000, svc_r, sim_r, queue_r, inhibit_r,
		async_lvl, async_en};

	always_comb
	begin
		sw_nxt = sw_r;
		mode_nxt = mode_r;
		queue_nxt = queue_r;
		svc_nxt = svc_r || SVC_I;
		sim_nxt = sim_r || SIM_I;
		take_nxt = take_r;
		take_pulse_nxt = 1'b0;
		ack_nxt = '0;
		inhibit_nxt = inhibit_r;
		body_ok_nxt = body_ok_r || LIST_BODY_OK_I;
		hdr_ok_nxt = hdr_ok_r || LIST_HDR_OK_I;
		bus_ack_nxt = bus_req;
		rdata_nxt = rdata_r;
		if (BOUNDARY_I || ITER_END_I)
		begin
			inhibit_nxt = 1'b0;
			body_ok_nxt = 1'b0;
			hdr_ok_nxt = 1'b0;
		end
		// software register writes
		if (bus_req && AVS_WRITE_I)
		begin
			case (AVS_ADDRESS_I)
				ipt_pkg::REG_STATUS_WORD:
				begin
					// [RQ18] software may clear bit 14 here
					sw_nxt = (sw_r & ~wmask) | (AVS_WRITEDATA_I & wmask);
				end
				ipt_pkg::REG_MODE:
				begin
					if (AVS_BYTEENABLE_I[0])
					begin
						mode_nxt = AVS_WRITEDATA_I[0] ? ipt_pkg::MODE_RUN
							: ipt_pkg::MODE_CONSOLE;
					end
				end
				default:
				begin
					sw_nxt = sw_r;
				end
			endcase
		end
		if (bus_req && AVS_READ_I)
		begin
			case (AVS_ADDRESS_I)
				ipt_pkg::REG_STATUS_WORD: rdata_nxt = sw_r;
				ipt_pkg::REG_MODE: rdata_nxt = {31'h0000_0000, run};
				ipt_pkg::REG_PENDING: rdata_nxt = pend_view;
				ipt_pkg::REG_LAST_TAKE: rdata_nxt = {24'h00_0000, take_r.cls,
					take_r.cause};
				ipt_pkg::REG_OLD_LOC: rdata_nxt = take_r.old_loc;
				ipt_pkg::REG_OLD_SW: rdata_nxt = take_r.old_sw;
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
		if (SW_LOAD_I)
		begin
			sw_nxt = SW_NEW_I;
			// [RQ21] queue test on new word, [RQ12] status-loading only
			if (queue_set)
			begin
				queue_nxt = 1'b1;
			end
		end
		if (HALT_I)
		begin
			mode_nxt = ipt_pkg::MODE_CONSOLE;
		end
		// wait bit forced low when entering run mode
		if (mode_r == ipt_pkg::MODE_CONSOLE && mode_nxt == ipt_pkg::MODE_RUN)
		begin
			sw_nxt[ipt_pkg::SW_WAIT_POS] = 1'b0;
		end
		take_nxt.old_sw = sw_r;
		take_nxt.cause = ipt_pkg::CAUSE_NONE;
		take_nxt.abort = 1'b0;
		take_nxt.old_loc = NEXT_LOC_I;
		take_nxt.cls = ipt_pkg::CLS_NONE;
		// [RQ5] faults taken at detection, [RQ14] one fault at a time
		if (run && fault_en)
		begin
			take_nxt.cls = ipt_pkg::CLS_FAULT;
			take_nxt.cause = cause;
			// [RQ8] faulting instruction is next logically executed
			take_nxt.old_loc = CUR_LOC_I;
			// [RQ6] abort, writes suppressed unless MULTI_OP_I, [RQ7] only this iteration
			take_nxt.abort = 1'b1;
			inhibit_nxt = !MULTI_OP_I;
		end
		// [RQ22] single highest request, lower ones stay pending
		else if (point)
		begin
			// [RQ11] precedence order
			if (queue_r)
			begin
				take_nxt.cls = ipt_pkg::CLS_QUEUE;
				// a queue test in this very cycle keeps it pending
				queue_nxt = queue_set;
			end
			else if (svc_r)
			begin
				take_nxt.cls = ipt_pkg::CLS_SVC;
				svc_nxt = SVC_I;
			end
			else if (sim_r)
			begin
				take_nxt.cls = ipt_pkg::CLS_SIM;
				sim_nxt = SIM_I;
			end
			else if (async_en[ipt_pkg::AS_POWER])
			begin
				take_nxt.cls = ipt_pkg::CLS_POWER;
				ack_nxt[ipt_pkg::AS_POWER] = 1'b1;
			end
			else if (async_en[ipt_pkg::AS_CONSOLE])
			begin
				take_nxt.cls = ipt_pkg::CLS_CONSOLE;
				ack_nxt[ipt_pkg::AS_CONSOLE] = 1'b1;
			end
			else if (async_en[ipt_pkg::AS_MALF])
			begin
				take_nxt.cls = ipt_pkg::CLS_MALF;
				ack_nxt[ipt_pkg::AS_MALF] = 1'b1;
			end
			else if (async_en[ipt_pkg::AS_IO])
			begin
				take_nxt.cls = ipt_pkg::CLS_IO;
				ack_nxt[ipt_pkg::AS_IO] = 1'b1;
			end
			// [RQ8] mid-iteration acceptance re-executes this instruction
			if (re_exec)
			begin
				take_nxt.old_loc = CUR_LOC_I;
			end
		end
		if (take_nxt.cls != ipt_pkg::CLS_NONE)
		begin
			take_pulse_nxt = 1'b1;
			// [RQ16] mark interrupted iteration, [RQ15] resume later
			if (mid_iter)
			begin
				take_nxt.old_sw[ipt_pkg::SW_IIP_POS] = 1'b1;
			end
		end
		else
		begin
			take_nxt = take_r;
		end
		// [RQ17] scratchpad resume follows bit 14
		resume_nxt = sw_nxt[ipt_pkg::SW_IIP_POS];
		// release the mask once the synchronised level has fallen
		held_nxt = (held_r & async_lvl) | ack_nxt;
	end

	always_ff @(posedge REF_CLK_I)
	begin
		if (RST_I)
		begin
			sw_r <= ipt_pkg::SW_RESET;
			mode_r <= ipt_pkg::MODE_CONSOLE;
			queue_r <= 1'b0;
			svc_r <= 1'b0;
			sim_r <= 1'b0;
			take_r <= '{cls: ipt_pkg::CLS_NONE, cause: ipt_pkg::CAUSE_NONE, abort: 1'b0,
				old_loc: ipt_pkg::LOC_RESET, old_sw: ipt_pkg::SW_RESET};
			take_pulse_r <= 1'b0;
			ack_r <= '0;
			inhibit_r <= 1'b0;
			body_ok_r <= 1'b0;
			hdr_ok_r <= 1'b0;
			resume_r <= 1'b0;
			held_r <= '0;
			bus_ack_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end
		else
		begin
			sw_r <= sw_nxt;
			mode_r <= mode_nxt;
			queue_r <= queue_nxt;
			svc_r <= svc_nxt;
			sim_r <= sim_nxt;
			take_r <= take_nxt;
			take_pulse_r <= take_pulse_nxt;
			ack_r <= ack_nxt;
			inhibit_r <= inhibit_nxt;
			body_ok_r <= body_ok_nxt;
			hdr_ok_r <= hdr_ok_nxt;
			resume_r <= resume_nxt;
			held_r <= held_nxt;
			bus_ack_r <= bus_ack_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !bus_ack_r;
	assign AVS_READDATA_O = rdata_r;
	assign ASYNC_ACK_O = ack_r;
	assign TAKE_INFO_O = take_r;
	assign TAKE_O = take_pulse_r;
	// [RQ6] writes held off from a non-multiple fault until the next boundary or iteration end
	assign WRITE_INHIBIT_O = inhibit_r;
	assign SCRATCH_RESUME_O = resume_r;
	// [RQ9] header only after body access
	assign HDR_WR_OK_O = LIST_OP_I && body_ok_r && !inhibit_r;
	// [RQ10] remove writes registers after element and header
	assign LIST_REG_WR_OK_O = LIST_REMOVE_I && body_ok_r && hdr_ok_r && !inhibit_r;
	assign STATUS_WORD_O = sw_r;
	assign RUN_MODE_O = run;
	assign WAIT_STATE_O = run && sw_r[ipt_pkg::SW_WAIT_POS];
endmodule

// file: design/ipt_pkg.sv
// constants, types and field layouts for the interrupt priority and timing unit
// Functional notes
// [RQ1] maskable requests gated by status-word enable bit
// [RQ2] supervisor call, simulated, illegal, console: unmasked
// [RQ3] asynchronous requests taken at instruction boundaries
// [RQ4] also taken at each iteration end
// [RQ5] faults taken at detection; queue service deferred
// [RQ6] fault aborts instruction, no register/memory change; writes stay enabled when MULTI_OP_I is high
// [RQ7] interruptible instruction: abort only current iteration
// [RQ8] saved location points to next logical instruction
// [RQ9] list header written only after body succeeded
// [RQ10] list remove: registers need element and header
// [RQ11] rank faults, queue, power, console, malfunction, I/O
// [RQ12] queue service only from status-loading instructions
// [RQ13] fault causes ranked in fixed order
// [RQ14] one fault pending; coincident requests by precedence
// [RQ15] resume iteration; repeat faulted iteration
// [RQ16] set iteration-in-progress in saved word, except control-store
// [RQ17] bit 14 set: resume from scratchpad state
// [RQ18] software clears bit 14 to abandon
// [RQ19] software preserves scratchpad while bit 14 set
// [RQ20] always console or run mode; wait only in run
// [RQ21] new word with bit 22: test queue, raise service
// [RQ22] take single highest pending request per point
package ipt_pkg;
	localparam int SW_W = 32;
	localparam int LOC_W = 32;
	// status word bits are numbered msb-first
	localparam int SW_IIP_NUM = 14;
	localparam int SW_WAIT_NUM = 16;
	localparam int SW_IO_EN_NUM = 17;
	localparam int SW_MALF_EN_NUM = 18;
	localparam int SW_ARITH_EN_NUM = 19;
	localparam int SW_ACC_EN_NUM = 21;
	localparam int SW_QUEUE_EN_NUM = 22;
	localparam int SW_IIP_POS = SW_W - 1 - SW_IIP_NUM;
	localparam int SW_WAIT_POS = SW_W - 1 - SW_WAIT_NUM;
	localparam int SW_IO_EN_POS = SW_W - 1 - SW_IO_EN_NUM;
	localparam int SW_MALF_EN_POS = SW_W - 1 - SW_MALF_EN_NUM;
	localparam int SW_ARITH_EN_POS = SW_W - 1 - SW_ARITH_EN_NUM;
	localparam int SW_ACC_EN_POS = SW_W - 1 - SW_ACC_EN_NUM;
	localparam int SW_QUEUE_EN_POS = SW_W - 1 - SW_QUEUE_EN_NUM;
	localparam logic [SW_W-1:0] SW_RESET = 32'h0000_0000;
	localparam logic [LOC_W-1:0] LOC_RESET = 32'h0000_0000;
	// fault cause vector, index 0 is highest
	localparam int FLT_N = 9;
	localparam int FLT_ACC_FETCH = 0;
	localparam int FLT_MEM_FETCH = 1;
	localparam int FLT_ILLEGAL = 2;
	localparam int FLT_SUBFN = 3;
	localparam int FLT_ALIGN = 4;
	localparam int FLT_ACC_DATA = 5;
	localparam int FLT_MEM_DATA = 6;
	localparam int FLT_FORMAT = 7;
	localparam int FLT_ARITH = 8;
	localparam logic [3:0] CAUSE_NONE = 4'hf;
	// asynchronous pin vector
	localparam int AS_N = 4;
	localparam int AS_POWER = 0;
	localparam int AS_CONSOLE = 1;
	localparam int AS_MALF = 2;
	localparam int AS_IO = 3;
	// register byte offsets
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] REG_STATUS_WORD = 5'h00;
	localparam logic [ADDR_W-1:0] REG_MODE = 5'h04;
	localparam logic [ADDR_W-1:0] REG_PENDING = 5'h08;
	localparam logic [ADDR_W-1:0] REG_LAST_TAKE = 5'h0c;
	localparam logic [ADDR_W-1:0] REG_OLD_LOC = 5'h10;
	localparam logic [ADDR_W-1:0] REG_OLD_SW = 5'h14;
	localparam logic [3:0] FLD_W4 = 4'h4;

	typedef enum logic [3:0] {
		CLS_NONE, CLS_FAULT, CLS_QUEUE, CLS_SVC, CLS_SIM, CLS_POWER,
		CLS_CONSOLE, CLS_MALF, CLS_IO
	} ipt_class_e;

	typedef enum logic {MODE_CONSOLE, MODE_RUN} ipt_mode_e;

	// acceptance record handed to the sequencer
	typedef struct packed {
		ipt_class_e cls;
		logic [3:0] cause;
		logic abort;
		logic [LOC_W-1:0] old_loc;
		logic [SW_W-1:0] old_sw;
	} ipt_take_s;
endpackage

// file: bench/ipt_unit_properties.sv
// property checker for the interrupt priority and timing unit
`timescale 1ns/100ps
module ipt_unit_properties (
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic AVS_WAITREQUEST_O,
	input wire logic [ipt_pkg::AS_N-1:0] ASYNC_ACK_O,
	input wire logic FAULT_I,
	input wire logic [ipt_pkg::FLT_N-1:0] FAULT_CAUSE_I,
	input wire logic BOUNDARY_I,
	input wire logic ITER_END_I,
	input wire logic ITER_INSTR_I,
	input wire logic CTRL_STORE_OP_I,
	input wire logic MULTI_OP_I,
	input wire logic [ipt_pkg::LOC_W-1:0] CUR_LOC_I,
	input wire logic LIST_OP_I,
	input wire logic LIST_BODY_OK_I,
	input wire ipt_pkg::ipt_take_s TAKE_INFO_O,
	input wire logic TAKE_O,
	input wire logic WRITE_INHIBIT_O,
	input wire logic HDR_WR_OK_O,
	input wire logic [ipt_pkg::SW_W-1:0] STATUS_WORD_O,
	input wire logic RUN_MODE_O
);
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);
	wire logic req = AVS_READ_I | AVS_WRITE_I;
	wire logic pt = BOUNDARY_I | (ITER_END_I & ITER_INSTR_I) | STATUS_WORD_O[ipt_pkg::SW_WAIT_POS];
	wire logic io_en = STATUS_WORD_O[ipt_pkg::SW_IO_EN_POS];
	wire logic mid = ITER_END_I & ITER_INSTR_I & !BOUNDARY_I & !CTRL_STORE_OP_I;
	wire logic tf = TAKE_O && TAKE_INFO_O.cls == ipt_pkg::CLS_FAULT;
	wire logic tio = TAKE_O && TAKE_INFO_O.cls == ipt_pkg::CLS_IO;
	a_one_wait: assert property (req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
		else $error("bus wait not single");
	a_idle_nowait: assert property (!req |-> !AVS_WAITREQUEST_O)
		else $error("wait without request");
	a_console_idle: assert property (!RUN_MODE_O |=> !TAKE_O)
		else $error("take in console mode");
	a_fault_take: assert property (FAULT_I && RUN_MODE_O && FAULT_CAUSE_I[2:0] == 3'h4 |=> tf
		&& TAKE_INFO_O.cause == 4'h2 && TAKE_INFO_O.old_loc == $past(CUR_LOC_I))
		else $error("fault take wrong");
	a_fault_abort: assert property (tf |-> TAKE_INFO_O.abort && WRITE_INHIBIT_O == !$past(MULTI_OP_I))
		else $error("fault abort wrong");
	a_inhibit_end: assert property (WRITE_INHIBIT_O && (BOUNDARY_I || ITER_END_I) && !FAULT_I
		|=> !WRITE_INHIBIT_O)
		else $error("inhibit not cleared");
	a_mask_io: assert property (tio |-> $past(io_en) && ASYNC_ACK_O[ipt_pkg::AS_IO])
		else $error("io take wrong");
	a_async_point: assert property (TAKE_O && TAKE_INFO_O.cls >= ipt_pkg::CLS_POWER |-> $past(pt))
		else $error("async take off point");
	a_iter_flag: assert property (TAKE_O && !tf && $past(mid) |-> TAKE_INFO_O.old_sw[ipt_pkg::SW_IIP_POS])
		else $error("iteration flag missing");
	a_hdr_order: assert property ($rose(LIST_OP_I) && !LIST_BODY_OK_I |-> !HDR_WR_OK_O)
		else $error("header early");
	c_fault: cover property (tf);
	c_queue: cover property (TAKE_O && TAKE_INFO_O.cls == ipt_pkg::CLS_QUEUE);
	c_hdr: cover property (HDR_WR_OK_O);
endmodule
bind ipt_unit ipt_unit_properties i_prop (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
	.AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
	.ASYNC_ACK_O(ASYNC_ACK_O), .FAULT_I(FAULT_I), .FAULT_CAUSE_I(FAULT_CAUSE_I),
	.BOUNDARY_I(BOUNDARY_I), .ITER_END_I(ITER_END_I), .ITER_INSTR_I(ITER_INSTR_I),
	.CTRL_STORE_OP_I(CTRL_STORE_OP_I), .MULTI_OP_I(MULTI_OP_I), .CUR_LOC_I(CUR_LOC_I),
	.LIST_OP_I(LIST_OP_I), .LIST_BODY_OK_I(LIST_BODY_OK_I), .TAKE_INFO_O(TAKE_INFO_O),
	.TAKE_O(TAKE_O), .WRITE_INHIBIT_O(WRITE_INHIBIT_O), .HDR_WR_OK_O(HDR_WR_OK_O),
	.STATUS_WORD_O(STATUS_WORD_O), .RUN_MODE_O(RUN_MODE_O));

// file: bench/ipt_src_model.sv
// interrupt source model: each request level stands until acknowledged
`timescale 1ns/100ps
module ipt_src_model (
	input wire logic clk_i, // bench clock
	input wire logic rst_i, // reset
	input wire logic [ipt_pkg::AS_N-1:0] raise_i, // new request pulses
	input wire logic [ipt_pkg::AS_N-1:0] ack_i, // acknowledge from unit
	output logic [ipt_pkg::AS_N-1:0] req_o // request levels
);
	logic [ipt_pkg::AS_N-1:0] req_r;
	logic [ipt_pkg::AS_N-1:0] req_nxt;
	always_comb
	begin
		req_nxt = (req_r | raise_i) & ~ack_i;
	end
	always_ff @(posedge clk_i)
	begin
		req_r <= rst_i ? '0 : req_nxt;
	end
	assign req_o = req_r;
endmodule

// file: bench/tb.sv
// self-checking bench for the interrupt priority and timing unit
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin failures++; $display("ERROR %s exp %h got %h", n, e, a); end end
module tb;
	localparam logic [31:0] IOE = 32'h1 << ipt_pkg::SW_IO_EN_POS;
	localparam logic [31:0] QEN = 32'h1 << ipt_pkg::SW_QUEUE_EN_POS;
	localparam logic [31:0] ITERATION_IN_PROGRESS = 32'h1 << ipt_pkg::SW_IIP_POS;
	localparam logic [31:0] WTB = 32'h1 << ipt_pkg::SW_WAIT_POS;
	localparam logic [31:0] CUR = 32'h0000_1000;
	localparam logic [31:0] NXT = 32'h0000_1004;
	logic clk = 0, rst = 1, rd = 0, wr = 0, wt, flt = 0, supervisor_call = 0, sim = 0, bnd = 0, itend = 0;
	logic iter = 0, cso = 0, multi = 0, swl = 0, swt = 0, qne = 0, halt = 0;
	logic lop = 0, lrem = 0, lbok = 0, lhok = 0, take, winh, sres, hok, rok, run, wst;
	logic [4:0] adr = '0;
	logic [3:0] be = '0, raise = '0, areq, ack;
	logic [8:0] fc = '0;
	logic [31:0] wd = '0, swn = '0, rdata, sw, q;
	ipt_pkg::ipt_take_s ti;
	ipt_pkg::ipt_class_e cl [4] = '{ipt_pkg::CLS_SVC, ipt_pkg::CLS_SIM,
		ipt_pkg::CLS_CONSOLE, ipt_pkg::CLS_IO};
	int failures = 0, checks = 0;
	always #10 clk = ~clk;
	ipt_src_model i_src (.clk_i(clk), .rst_i(rst), .raise_i(raise), .ack_i(ack), .req_o(areq));
	ipt_unit i_dut (.REF_CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
		.AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(be), .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdata),
		.AVS_WAITREQUEST_O(wt), .ASYNC_REQ_I(areq), .ASYNC_ACK_O(ack), .FAULT_I(flt),
		.FAULT_CAUSE_I(fc), .SVC_I(supervisor_call), .SIM_I(sim), .BOUNDARY_I(bnd), .ITER_END_I(itend),
		.ITER_INSTR_I(iter), .CTRL_STORE_OP_I(cso), .MULTI_OP_I(multi), .CUR_LOC_I(CUR),
		.NEXT_LOC_I(NXT), .SW_LOAD_I(swl), .SW_LOAD_TEST_I(swt), .SW_NEW_I(swn),
		.QUEUE_NONEMPTY_I(qne), .HALT_I(halt), .LIST_OP_I(lop), .LIST_REMOVE_I(lrem),
		.LIST_BODY_OK_I(lbok), .LIST_HDR_OK_I(lhok), .TAKE_INFO_O(ti), .TAKE_O(take),
		.WRITE_INHIBIT_O(winh), .SCRATCH_RESUME_O(sres), .HDR_WR_OK_O(hok),
		.LIST_REG_WR_OK_O(rok), .STATUS_WORD_O(sw), .RUN_MODE_O(run), .WAIT_STATE_O(wst));
	task automatic close_out;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// one bus transfer, held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		logic ok;
		ok = 1'b0;
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		be <= 4'hf;
		while (!ok)
		begin
			#1;
			ok = (wt === 1'b0);
			if (ok)
				q = rdata;
			@(posedge clk);
		end
		rd <= 0;
		wr <= 0;
		be <= 4'h0;
		@(posedge clk);
	endtask
	// one-cycle source pulses
	task automatic pend(input logic [3:0] r, input logic s, input logic m);
		raise <= r;
		supervisor_call <= s;
		sim <= m;
		@(posedge clk);
		raise <= 0;
		supervisor_call <= 0;
		sim <= 0;
	endtask
	// acceptance point or fault, then take check
	task automatic ev(input logic b, input logic ie, input logic f, input logic [8:0] c,
		input logic et, input ipt_pkg::ipt_class_e ec, input string nm);
		repeat (3) @(posedge clk);
		bnd <= b;
		itend <= ie;
		flt <= f;
		fc <= c;
		@(posedge clk);
		bnd <= 0;
		itend <= 0;
		flt <= 0;
		#1;
		`CHK({nm, " take"}, et, take)
		if (et)
			`CHK({nm, " class"}, ec, ti.cls)
		@(posedge clk);
	endtask
	initial
	begin
		repeat (11) @(posedge clk);
		#1;
		`CHK("reset sw", 32'h0, sw)
		`CHK("reset run", 1'b0, run)
		@(posedge clk);
		rst <= 0;
		@(posedge clk);
		bus(0, ipt_pkg::REG_MODE, 0);
		`CHK("mode", 32'h0, q)
		bus(0, 5'h1c, 0);
		`CHK("unmapped", 32'h0, q)
		pend(4'h2, 0, 0);
		ev(1, 0, 0, '0, 0, ipt_pkg::CLS_NONE, "console mode");
		bus(1, ipt_pkg::REG_MODE, 32'h1);
		`CHK("run", 1'b1, run)
		ev(1, 0, 0, '0, 1, ipt_pkg::CLS_CONSOLE, "attention");
		`CHK("next loc", NXT, ti.old_loc)
		$display("test modes done");
		pend(4'h8, 0, 0);
		ev(1, 0, 0, '0, 0, ipt_pkg::CLS_NONE, "io masked");
		bus(0, ipt_pkg::REG_PENDING, 0);
		`CHK("pending", 32'h0000_0080, q)
		bus(1, ipt_pkg::REG_STATUS_WORD, IOE);
		bus(0, ipt_pkg::REG_STATUS_WORD, 0);
		`CHK("sw read", IOE, q)
		ev(1, 0, 0, '0, 1, ipt_pkg::CLS_IO, "io enabled");
		$display("test mask done");
		pend(4'ha, 1, 1);
		for (int i = 0; i < 4; i++)
			ev(1, 0, 0, '0, 1, cl[i], "rank");
		$display("test rank done");
		pend(4'h8, 0, 0);
		ev(1, 0, 1, 9'h014, 1, ipt_pkg::CLS_FAULT, "fault");
		`CHK("cause", 4'h2, ti.cause)
		`CHK("abort", 1'b1, ti.abort)
		`CHK("fault loc", CUR, ti.old_loc)
		`CHK("inhibit", 1'b1, winh)
		ev(1, 0, 0, '0, 1, ipt_pkg::CLS_IO, "after fault");
		`CHK("inhibit end", 1'b0, winh)
		multi <= 1;
		ev(0, 0, 1, 9'h008, 1, ipt_pkg::CLS_FAULT, "multi fault");
		`CHK("multi inhibit", 1'b0, winh)
		multi <= 0;
		$display("test fault done");
		iter <= 1;
		pend(4'h0, 0, 1);
		ev(0, 1, 0, '0, 1, ipt_pkg::CLS_SIM, "iteration");
		`CHK("iter loc", CUR, ti.old_loc)
		`CHK("iter flag", ITERATION_IN_PROGRESS, ti.old_sw & ITERATION_IN_PROGRESS)
		cso <= 1;
		pend(4'h0, 1, 0);
		ev(0, 1, 0, '0, 1, ipt_pkg::CLS_SVC, "ctrl store");
		`CHK("cs flag", 32'h0, ti.old_sw & ITERATION_IN_PROGRESS)
		`CHK("cs loc", CUR, ti.old_loc)
		cso <= 0;
		iter <= 0;
		bus(1, ipt_pkg::REG_STATUS_WORD, IOE | ITERATION_IN_PROGRESS);
		`CHK("resume", 1'b1, sres)
		// abandon the interrupted iteration
		bus(1, ipt_pkg::REG_STATUS_WORD, IOE);
		`CHK("no resume", 1'b0, sres)
		$display("test iteration done");
		swn <= IOE | QEN;
		qne <= 1;
		swl <= 1;
		@(posedge clk);
		swl <= 0;
		ev(1, 0, 0, '0, 0, ipt_pkg::CLS_NONE, "plain load");
		swt <= 1;
		swl <= 1;
		@(posedge clk);
		swl <= 0;
		swt <= 0;
		ev(1, 0, 0, '0, 1, ipt_pkg::CLS_QUEUE, "queue");
		bus(0, ipt_pkg::REG_LAST_TAKE, 0);
		`CHK("last take", 32'h0000_002f, q)
		qne <= 0;
		$display("test queue done");
		lop <= 1;
		lrem <= 1;
		repeat (2) @(posedge clk);
		`CHK("hdr early", 1'b0, hok)
		`CHK("reg early", 1'b0, rok)
		lbok <= 1;
		@(posedge clk);
		lbok <= 0;
		@(posedge clk);
		`CHK("hdr ok", 1'b1, hok)
		`CHK("reg mid", 1'b0, rok)
		lhok <= 1;
		@(posedge clk);
		lhok <= 0;
		@(posedge clk);
		`CHK("reg ok", 1'b1, rok)
		lop <= 0;
		lrem <= 0;
		bus(1, ipt_pkg::REG_STATUS_WORD, IOE | WTB);
		`CHK("waiting", 1'b1, wst)
		halt <= 1;
		@(posedge clk);
		halt <= 0;
		repeat (2) @(posedge clk);
		`CHK("halted", 1'b0, run)
		`CHK("halted wait", 1'b0, wst)
		bus(1, ipt_pkg::REG_MODE, 32'h1);
		`CHK("wait cleared", 32'h0, sw & WTB)
		$display("test list and halt done");
		close_out;
	end
	initial
	begin
		#100000;
		failures++;
		close_out;
	end
endmodule
